// ### hw/mem_map_pkg.sv
// constants for the data-side memory map
package mem_map_pkg;
    localparam int XADDR_W = 16;
    localparam int XRAM_BYTES = 4608;
    localparam logic [15:0] XRAM_LAST = 16'h11FF;
    localparam logic [15:0] EE_WIN_BASE = 16'h4040;
    localparam logic [15:0] EE_WIN_LAST = 16'h404F;
    localparam int EE_BYTES = 16;
    localparam logic [7:0] SP_ADDR = 8'h81;
    localparam logic [7:0] PSW_ADDR = 8'hD0;
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [7:0] PSW_RESET = 8'h00;
    localparam logic [7:0] BANK_TOP = 8'h1F;
    localparam logic [7:0] BIT_BASE = 8'h20;
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam int PSW_BANK_LO = 3;
    localparam int PSW_BANK_HI = 4;
    localparam logic [3:0] BITABLE_NIB0 = 4'h0;
    localparam logic [3:0] BITABLE_NIB8 = 4'h8;
    localparam logic [2:0] RAMSEL_LSB = 3'h0;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_DIRECT,
        OP_INDIRECT,
        OP_REG,
        OP_PUSH,
        OP_POP
    } iop_e;
endpackage

// ### hw/byte_ram.sv
// single-port byte memory with registered read
module byte_ram #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic clk_in,
    input wire logic wr_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk_in) begin
        if (wr_in) begin
            mem[addr_in] <= wdata_in;
        end
        rdata_out <= mem[addr_in];
    end
endmodule

// ### hw/eeprom_window.sv
// read-only window onto the 16-byte rewritable array
module eeprom_window (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic prog_in,
    input wire logic [127:0] prog_data_in,
    input wire logic [3:0] idx_in,
    output logic [7:0] rdata_out,
    output logic [127:0] bit_changes_out
);
    logic [127:0] cells;

    // whole-array programming only
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cells <= '0;
            bit_changes_out <= '0;
        end else if (prog_in) begin
            cells <= prog_data_in;
            bit_changes_out <= cells ^ prog_data_in;
        end else begin
            bit_changes_out <= '0;
        end
    end

    // byte 0 is most significant
    always_ff @(posedge clk_in) begin
        rdata_out <= cells[8'(127 - 8 * idx_in) -: 8];
    end
endmodule

// ### hw/mcu_data_memory_map.sv
// data-side memory map: xram, internal ram, sfr decode, eeprom window
//
// Behaviour
// - one 4.5 kB ram serves code fetch, code reads and external moves
// - 64 kB external data space reached only by external moves
// - bytes 0x00-0x1F form four banks of eight working registers
// - bank chosen by status word bits 3 (low) and 4 (high)
// - bank n maps registers to bytes 8n to 8n+7
// - indirect pointer is working register zero or one of active bank
// - bytes 0x20-0x2F also give 128 bits, bit addr = 8*off+pos
// - bit versus byte access chosen by operand type only
// - stack pointer at 0x81; push increments then stores
// - reset loads stack pointer with 0x07
// - stack anywhere in 256 bytes, depth up to 256
// - direct access at 0x80-0xFF goes to special registers
// - indirect access above 0x7F reaches the upper internal ram
// - special registers at x0/x8 are bit addressable, others byte only
// - mapped hardware registers act as plain external data locations
// - multi-byte mapped registers are big endian
// - one-time memory unmapped and never writable by register
// - rewritable array written only whole, all 16 bytes at once
// - unchanged bits during programming cause no wear
module mcu_data_memory_map (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // code fetch / code read port
    input wire logic code_rd_in,
    input wire logic [15:0] code_addr_in,
    output logic [7:0] code_rdata_out,
    // external data port (external move instruction class)
    input wire logic xd_rd_in,
    input wire logic xd_wr_in,
    input wire logic [15:0] xd_addr_in,
    input wire logic [7:0] xd_wdata_in,
    output logic [7:0] xd_rdata_out,
    // internal data port
    input wire logic [2:0] iop_in,
    input wire logic i_wr_in,
    input wire logic i_bit_in,
    input wire logic [7:0] i_addr_in,
    input wire logic [2:0] i_reg_in,
    input wire logic i_ptr_sel_in,
    input wire logic [7:0] i_wdata_in,
    output logic [7:0] i_rdata_out,
    output logic i_bit_rdata_out,
    output logic i_sfr_hit_out,
    // special register space beyond those held here
    output logic sfr_rd_out,
    output logic sfr_wr_out,
    output logic [7:0] sfr_addr_out,
    output logic [7:0] sfr_wdata_out,
    output logic sfr_bit_out,
    input wire logic [7:0] sfr_rdata_in,
    // state views
    output logic [7:0] stack_pointer_out,
    output logic [7:0] program_status_word_out,
    // rewritable array programming from the rom routine
    input wire logic ee_prog_in,
    input wire logic [127:0] ee_prog_data_in,
    output logic [127:0] ee_bit_changes_out
);
    logic [7:0] stack_pointer;
    logic [7:0] program_status_word;
    logic [1:0] bank;
    logic [7:0] bank_base;
    logic [7:0] i_ram_addr;
    logic [7:0] next_ram_addr;
    logic ram_wr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_rdata;
    logic [7:0] ptr_value;
    logic ptr_phase;
    logic rmw_pend;
    logic [7:0] rmw_addr_q;
    logic rmw_bit_q;
    logic is_sfr;
    logic sfr_bitable;
    logic [7:0] bit_byte;
    logic [2:0] bit_pos;
    logic [7:0] hold_rmw;
    logic [12:0] xram_addr;
    logic xram_wr;
    logic [7:0] xram_rdata;
    logic [7:0] code_ram_rdata;
    logic xd_in_ram;
    logic xd_in_ee;
    logic xd_in_ram_q;
    logic xd_in_ee_q;
    logic code_in_ram_q;
    logic [7:0] ee_rdata;
    logic [2:0] bit_pos_q;
    logic sfr_q;
    logic [7:0] local_sfr_q;
    logic local_hit_q;
    logic [7:0] push_data_q;
    logic push_pend;

    // bank select from status word
    assign bank = {program_status_word[mem_map_pkg::PSW_BANK_HI],
                   program_status_word[mem_map_pkg::PSW_BANK_LO]};
    assign bank_base = {3'h0, bank, 3'h0};

    // bit address to byte/position
    assign sfr_bitable = (bit_byte[3:0] == mem_map_pkg::BITABLE_NIB0)
        || (bit_byte[3:0] == mem_map_pkg::BITABLE_NIB8);
    always_comb begin
        if (i_addr_in[7]) begin
            bit_byte = {i_addr_in[7:3], 3'h0};
        end else begin
            bit_byte = mem_map_pkg::BIT_BASE + {4'h0, i_addr_in[6:3]};
        end
        bit_pos = i_addr_in[2:0];
    end

    // decode target by addressing mode and operand type
    always_comb begin
        is_sfr = 1'b0;
        i_ram_addr = i_addr_in;
        unique case (mem_map_pkg::iop_e'(iop_in))
            mem_map_pkg::OP_DIRECT: begin
                if (i_bit_in) begin
                    i_ram_addr = bit_byte;
                    is_sfr = i_addr_in[7];
                end else begin
                    is_sfr = i_addr_in[7];
                end
            end
            mem_map_pkg::OP_INDIRECT: i_ram_addr = ram_rdata;
            mem_map_pkg::OP_REG: i_ram_addr = bank_base | {5'h0, i_reg_in};
            mem_map_pkg::OP_PUSH: i_ram_addr = stack_pointer + 8'h01;
            mem_map_pkg::OP_POP: i_ram_addr = stack_pointer;
            default: i_ram_addr = i_addr_in;
        endcase
    end

    // indirect: fetch pointer register first, then access
    assign ptr_value = bank_base | {7'h00, i_ptr_sel_in};
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ptr_phase <= 1'b0;
        end else begin
            ptr_phase <= iop_in == mem_map_pkg::OP_INDIRECT && !ptr_phase;
        end
    end

    assign next_ram_addr = (iop_in == mem_map_pkg::OP_INDIRECT && !ptr_phase)
        ? ptr_value : i_ram_addr;
    assign ram_wr = i_wr_in && !is_sfr && !i_bit_in
        && iop_in != mem_map_pkg::OP_NONE
        && !(iop_in == mem_map_pkg::OP_INDIRECT && !ptr_phase);
    assign ram_wdata = i_wdata_in;

    // 256 internal bytes, lower and upper halves
    byte_ram #(.DEPTH(256), .AW(8)) iram_u (
        .clk_in(clk_in),
        .wr_in(ram_wr || push_pend || rmw_pend),
        .addr_in(push_pend ? stack_pointer
            : rmw_pend ? rmw_addr_q : next_ram_addr),
        .wdata_in(push_pend ? push_data_q
            : rmw_pend ? hold_rmw : ram_wdata),
        .rdata_out(ram_rdata)
    );

    // push: increment pointer, then store at new location
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            push_pend <= 1'b0;
            push_data_q <= 8'h00;
        end else begin
            push_pend <= 1'b0;
            if (iop_in == mem_map_pkg::OP_PUSH) begin
                push_pend <= 1'b1;
                push_data_q <= i_wdata_in;
            end
        end
    end

    // stack pointer and status word held here
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            stack_pointer <= mem_map_pkg::SP_RESET;
        end else if (iop_in == mem_map_pkg::OP_PUSH) begin
            stack_pointer <= stack_pointer + 8'h01;
        end else if (iop_in == mem_map_pkg::OP_POP) begin
            stack_pointer <= stack_pointer - 8'h01;
        end else if (is_sfr && i_wr_in && !i_bit_in
                     && i_addr_in == mem_map_pkg::SP_ADDR) begin
            stack_pointer <= i_wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            program_status_word <= mem_map_pkg::PSW_RESET;
        end else if (is_sfr && i_wr_in && !i_bit_in
                     && i_addr_in == mem_map_pkg::PSW_ADDR) begin
            program_status_word <= i_wdata_in;
        end else if (is_sfr && i_wr_in && i_bit_in && sfr_bitable
                     && bit_byte == mem_map_pkg::PSW_ADDR) begin
            program_status_word[bit_pos] <= i_wdata_in[0];
        end
    end

    // bit writes to ram: read the byte, write it back next cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rmw_pend <= 1'b0;
            rmw_addr_q <= 8'h00;
            rmw_bit_q <= 1'b0;
        end else begin
            rmw_pend <= iop_in == mem_map_pkg::OP_DIRECT && i_wr_in
                && i_bit_in && !is_sfr;
            rmw_addr_q <= bit_byte;
            rmw_bit_q <= i_wdata_in[0];
        end
    end

    always_comb begin
        hold_rmw = ram_rdata;
        hold_rmw[bit_pos_q] = rmw_bit_q;
    end

    // outward special register strobes; non-bitable bit access dropped
    always_comb begin
        sfr_rd_out = is_sfr && !i_wr_in && (!i_bit_in || sfr_bitable);
        sfr_wr_out = is_sfr && i_wr_in && (!i_bit_in || sfr_bitable);
        sfr_addr_out = i_bit_in ? bit_byte : i_addr_in;
        sfr_wdata_out = i_wdata_in;
        sfr_bit_out = i_bit_in;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            bit_pos_q <= 3'h0;
            sfr_q <= 1'b0;
            local_hit_q <= 1'b0;
            local_sfr_q <= 8'h00;
        end else begin
            bit_pos_q <= bit_pos;
            sfr_q <= is_sfr;
            local_hit_q <= sfr_addr_out == mem_map_pkg::SP_ADDR
                || sfr_addr_out == mem_map_pkg::PSW_ADDR;
            local_sfr_q <= (sfr_addr_out == mem_map_pkg::SP_ADDR)
                ? stack_pointer : program_status_word;
        end
    end

    // internal read data
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            i_rdata_out <= 8'h00;
            i_bit_rdata_out <= 1'b0;
            i_sfr_hit_out <= 1'b0;
        end else begin
            i_sfr_hit_out <= sfr_q;
            if (sfr_q) begin
                i_rdata_out <= local_hit_q ? local_sfr_q : sfr_rdata_in;
                i_bit_rdata_out <= local_hit_q ? local_sfr_q[bit_pos_q]
                    : sfr_rdata_in[bit_pos_q];
            end else begin
                i_rdata_out <= ram_rdata;
                i_bit_rdata_out <= ram_rdata[bit_pos_q];
            end
        end
    end

    assign stack_pointer_out = stack_pointer;
    assign program_status_word_out = program_status_word;

    // external data decode
    assign xd_in_ram = xd_addr_in <= mem_map_pkg::XRAM_LAST;
    assign xd_in_ee = xd_addr_in >= mem_map_pkg::EE_WIN_BASE
        && xd_addr_in <= mem_map_pkg::EE_WIN_LAST;
    assign xram_wr = xd_wr_in && xd_in_ram;
    assign xram_addr = xd_addr_in[12:0];

    // shared code/data ram: data port writes, both ports read
    logic [7:0] xram [mem_map_pkg::XRAM_BYTES];
    always_ff @(posedge clk_in) begin
        if (xram_wr) begin
            xram[xram_addr] <= xd_wdata_in;
        end
        xram_rdata <= xram[xram_addr];
        code_ram_rdata <= xram[code_addr_in[12:0]];
    end

    eeprom_window ee_u (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .prog_in(ee_prog_in),
        .prog_data_in(ee_prog_data_in),
        .idx_in(xd_addr_in[3:0]),
        .rdata_out(ee_rdata),
        .bit_changes_out(ee_bit_changes_out)
    );

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            xd_in_ram_q <= 1'b0;
            xd_in_ee_q <= 1'b0;
            code_in_ram_q <= 1'b0;
        end else begin
            xd_in_ram_q <= xd_rd_in && xd_in_ram;
            xd_in_ee_q <= xd_rd_in && xd_in_ee;
            code_in_ram_q <= code_rd_in
                && code_addr_in <= mem_map_pkg::XRAM_LAST;
        end
    end

    always_comb begin
        xd_rdata_out = 8'h00;
        if (xd_in_ram_q) begin
            xd_rdata_out = xram_rdata;
        end else if (xd_in_ee_q) begin
            xd_rdata_out = ee_rdata;
        end
        code_rdata_out = code_in_ram_q ? code_ram_rdata : 8'h00;
    end
endmodule

// ### bench/mcu_data_memory_map_properties.sv
// concurrent checks on the memory map ports
module mcu_data_memory_map_properties (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic xd_rd_in,
    input wire logic [15:0] xd_addr_in,
    input wire logic [7:0] xd_rdata_out,
    input wire logic [2:0] iop_in,
    input wire logic i_wr_in,
    input wire logic i_bit_in,
    input wire logic [7:0] i_addr_in,
    input wire logic [7:0] i_wdata_in,
    input wire logic sfr_rd_out,
    input wire logic sfr_wr_out,
    input wire logic [7:0] sfr_addr_out,
    input wire logic sfr_bit_out,
    input wire logic [7:0] stack_pointer_out,
    input wire logic [7:0] program_status_word_out,
    input wire logic ee_prog_in,
    input wire logic [127:0] ee_prog_data_in,
    input wire logic [127:0] ee_bit_changes_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    logic [127:0] ee_copy;
    logic [7:0] win_byte;
    logic direct_hi;
    logic in_win;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ee_copy <= 128'h0;
        end else if (ee_prog_in) begin
            ee_copy <= ee_prog_data_in;
        end
    end
    assign win_byte = ee_copy[127 - 8 * int'(xd_addr_in[3:0]) -: 8];
    assign in_win = xd_addr_in >= mem_map_pkg::EE_WIN_BASE
        && xd_addr_in <= mem_map_pkg::EE_WIN_LAST;
    assign direct_hi = iop_in == mem_map_pkg::OP_DIRECT && !i_bit_in
        && i_addr_in[7] && i_addr_in != mem_map_pkg::SP_ADDR
        && i_addr_in != mem_map_pkg::PSW_ADDR;
    sequence push_req;
        iop_in == mem_map_pkg::OP_PUSH;
    endsequence
    sequence sp_bumped;
        stack_pointer_out == $past(stack_pointer_out) + 8'h01;
    endsequence
    AST_SP_RESET: assert property ($fell(sys_rst_in) |->
        stack_pointer_out == 8'h07 && program_status_word_out == 8'h00)
        else $error("stack pointer or status word wrong after reset");
    AST_PUSH_BUMP: assert property (push_req |=> sp_bumped)
        else $error("push did not advance the stack pointer by one");
    AST_PSW_WRITE: assert property (iop_in == mem_map_pkg::OP_DIRECT
        && i_wr_in && !i_bit_in && i_addr_in == mem_map_pkg::PSW_ADDR
        |=> program_status_word_out == $past(i_wdata_in))
        else $error("status word write not taken");
    AST_DIRECT_SFR: assert property (direct_hi |->
        (i_wr_in ? sfr_wr_out : sfr_rd_out) && !sfr_bit_out
        && sfr_addr_out == i_addr_in)
        else $error("direct upper access missed the special space");
    AST_NO_SFR: assert property ((iop_in == mem_map_pkg::OP_INDIRECT
        || (iop_in == mem_map_pkg::OP_DIRECT && !i_addr_in[7]))
        |-> !sfr_rd_out && !sfr_wr_out)
        else $error("ram access leaked into the special space");
    AST_SFR_BIT_NIB: assert property (iop_in == mem_map_pkg::OP_DIRECT
        && i_bit_in && i_addr_in[7] |-> (sfr_rd_out || sfr_wr_out)
        && sfr_bit_out && sfr_addr_out == {i_addr_in[7:3], 3'h0})
        else $error("bit access missed its bit-addressable register");
    AST_WIN_READ: assert property (xd_rd_in && in_win
        |=> xd_rdata_out == $past(win_byte))
        else $error("window read returned the wrong byte");
    AST_NO_WEAR: assert property (ee_prog_in
        && ee_prog_data_in == ee_copy
        |-> ee_bit_changes_out == 128'h0 ##1 ee_bit_changes_out == 128'h0)
        else $error("unchanged program reported bit changes");
endmodule
bind mcu_data_memory_map mcu_data_memory_map_properties
    mcu_data_memory_map_properties_inst (.clk_in, .sys_rst_in, .xd_rd_in,
    .xd_addr_in, .xd_rdata_out, .iop_in, .i_wr_in, .i_bit_in, .i_addr_in,
    .i_wdata_in, .sfr_rd_out, .sfr_wr_out, .sfr_addr_out, .sfr_bit_out,
    .stack_pointer_out, .program_status_word_out, .ee_prog_in,
    .ee_prog_data_in, .ee_bit_changes_out);

// ### bench/sfr_bank_model.sv
// model of the special registers held outside the map
module sfr_bank_model (
    input wire logic clk_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] regs [256];
    logic [7:0] last = 8'h00;
    logic answering = 1'b0;
    initial begin
        foreach (regs[i]) regs[i] = 8'h00;
    end
    always @(posedge clk_in) begin
        if (wr_in) begin
            regs[addr_in] <= wdata_in;
        end
        answering <= rd_in;
        if (rd_in) begin
            last <= regs[addr_in];
        end
    end
    // answer stands the cycle after the strobe, else the inverse
    always_comb rdata_out = answering ? last : ~last;
endmodule

// ### bench/test_mcu_data_memory_map.sv
// self-checking bench for the data-side memory map
module test_mcu_data_memory_map;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [127:0] PAT = 128'h0123456789ABCDEF_F0E1D2C3B4A59687;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, code_rd_in = 1'b0;
    logic xd_rd_in = 1'b0, xd_wr_in = 1'b0, i_wr_in = 1'b0;
    logic i_bit_in = 1'b0, i_ptr_sel_in = 1'b0, ee_prog_in = 1'b0;
    logic [15:0] code_addr_in = 16'h0000, xd_addr_in = 16'h0000;
    logic [7:0] xd_wdata_in = 8'h00, i_addr_in = 8'h00, i_wdata_in = 8'h00;
    logic [2:0] iop_in = 3'h0, i_reg_in = 3'h0;
    logic [127:0] ee_prog_data_in = 128'h0, ee_bit_changes_out;
    logic [7:0] code_rdata_out, xd_rdata_out, i_rdata_out, sfr_addr_out;
    logic [7:0] sfr_wdata_out, sfr_rdata_in, stack_pointer_out;
    logic [7:0] program_status_word_out, got;
    logic i_bit_rdata_out, i_sfr_hit_out, sfr_rd_out, sfr_wr_out, sfr_bit_out;
    int n_errors = 0, checks = 0, cycles = 0;
    mcu_data_memory_map mcu_data_memory_map_inst (.clk_in, .sys_rst_in,
        .code_rd_in, .code_addr_in, .code_rdata_out, .xd_rd_in, .xd_wr_in,
        .xd_addr_in, .xd_wdata_in, .xd_rdata_out, .iop_in, .i_wr_in,
        .i_bit_in, .i_addr_in, .i_reg_in, .i_ptr_sel_in, .i_wdata_in,
        .i_rdata_out, .i_bit_rdata_out, .i_sfr_hit_out, .sfr_rd_out,
        .sfr_wr_out, .sfr_addr_out, .sfr_wdata_out, .sfr_bit_out,
        .sfr_rdata_in, .stack_pointer_out, .program_status_word_out,
        .ee_prog_in, .ee_prog_data_in, .ee_bit_changes_out);
    sfr_bank_model sfr_bank_model_inst (.clk_in, .rd_in(sfr_rd_out),
        .wr_in(sfr_wr_out), .addr_in(sfr_addr_out), .wdata_in(sfr_wdata_out),
        .rdata_out(sfr_rdata_in));
    always #5 clk_in = ~clk_in;
    task automatic end_sim;
        if (n_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask
    // one internal op; indirect is held for its two cycles
    task automatic op(input logic [2:0] o, input logic wr, bt,
                      input logic [7:0] a, wd);
        iop_in = o;
        i_wr_in = wr;
        i_bit_in = bt;
        i_addr_in = a;
        i_reg_in = a[2:0];
        i_ptr_sel_in = a[0];
        i_wdata_in = wd;
        if (o == 3'h2) begin
            @(posedge clk_in);
        end
        tick();
        iop_in = 3'h0;
        i_wr_in = 1'b0;
        i_bit_in = 1'b0;
        tick();
    endtask
    task automatic xd(input logic wr, input logic [15:0] a,
                      input logic [7:0] wd, output logic [7:0] rd);
        xd_wr_in = wr;
        xd_rd_in = !wr;
        xd_addr_in = a;
        xd_wdata_in = wd;
        tick();
        rd = xd_rdata_out;
        xd_wr_in = 1'b0;
        xd_rd_in = 1'b0;
        tick();
    endtask
    task automatic ee_prog;
        ee_prog_data_in = PAT;
        ee_prog_in = 1'b1;
        tick();
        ee_prog_in = 1'b0;
        tick();
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        #1 sys_rst_in = 1'b0;
        check("sp", stack_pointer_out, 8'h07);
        check("psw", program_status_word_out, 8'h00);
        op(3'h4, 1'b0, 1'b0, 8'h00, 8'hA5);
        check("sp", stack_pointer_out, 8'h08);
        tick();
        op(3'h1, 1'b0, 1'b0, 8'h08, 8'h00);
        check("push", i_rdata_out, 8'hA5);
        for (int b = 0; b < 4; b++) begin
            op(3'h1, 1'b1, 1'b0, 8'hD0, 8'(b << 3));
            check("psw", program_status_word_out, 8'(b << 3));
            op(3'h3, 1'b1, 1'b0, 8'h03, 8'(8'h40 + b));
            op(3'h1, 1'b0, 1'b0, 8'(8 * b + 3), 8'h00);
            check("bank", i_rdata_out, 8'(8'h40 + b));
        end
        op(3'h1, 1'b1, 1'b0, 8'h81, 8'h8F);
        op(3'h4, 1'b0, 1'b0, 8'h00, 8'h77);
        check("sp", stack_pointer_out, 8'h90);
        tick();
        op(3'h3, 1'b1, 1'b0, 8'h01, 8'h90);
        op(3'h2, 1'b0, 1'b0, 8'h01, 8'h00);
        check("upper", i_rdata_out, 8'h77);
        op(3'h1, 1'b1, 1'b0, 8'h90, 8'h3C);
        op(3'h2, 1'b1, 1'b0, 8'h01, 8'h55);
        op(3'h1, 1'b0, 1'b0, 8'h90, 8'h00);
        check("sfr", i_rdata_out, 8'h3C);
        check("hit", {7'h00, i_sfr_hit_out}, 8'h01);
        op(3'h1, 1'b0, 1'b0, 8'h81, 8'h00);
        check("sp read", i_rdata_out, 8'h90);
        op(3'h5, 1'b0, 1'b0, 8'h00, 8'h00);
        check("pop", i_rdata_out, 8'h55);
        check("sp", stack_pointer_out, 8'h8F);
        op(3'h1, 1'b1, 1'b0, 8'h22, 8'h00);
        op(3'h1, 1'b1, 1'b1, 8'h13, 8'h01);
        op(3'h1, 1'b0, 1'b0, 8'h22, 8'h00);
        check("bitbyte", i_rdata_out, 8'h08);
        op(3'h1, 1'b0, 1'b0, 8'h13, 8'h00);
        check("byte", i_rdata_out, 8'h42);
        op(3'h1, 1'b0, 1'b1, 8'h13, 8'h00);
        check("bit", {7'h00, i_bit_rdata_out}, 8'h01);
        op(3'h1, 1'b1, 1'b0, 8'h88, 8'h08);
        op(3'h1, 1'b0, 1'b1, 8'h8B, 8'h00);
        check("sfr bit", {7'h00, i_bit_rdata_out}, 8'h01);
        op(3'h1, 1'b0, 1'b1, 8'h8A, 8'h00);
        check("sfr bit", {7'h00, i_bit_rdata_out}, 8'h00);
        xd(1'b1, 16'h11FF, 8'h3C, got);
        xd(1'b0, 16'h11FF, 8'h00, got);
        check("xram", got, 8'h3C);
        code_rd_in = 1'b1;
        code_addr_in = 16'h11FF;
        tick();
        code_rd_in = 1'b0;
        check("code", code_rdata_out, 8'h3C);
        xd(1'b1, 16'h1200, 8'h5A, got);
        xd(1'b0, 16'h1200, 8'h00, got);
        check("unmapped", got, 8'h00);
        ee_prog();
        for (int i = 0; i < 16; i++) begin
            xd(1'b0, 16'h4040 + 16'(i), 8'h00, got);
            check("window", got, PAT[127 - 8 * i -: 8]);
        end
        xd(1'b1, 16'h4040, 8'hFF, got);
        xd(1'b0, 16'h4040, 8'h00, got);
        check("window ro", got, 8'h01);
        ee_prog();
        xd(1'b0, 16'h404F, 8'h00, got);
        check("reprog", got, 8'h87);
        end_sim();
    end
endmodule
